// [design/companion_pkg.sv]
package companion_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned READY_TIME_MS = 60;
  localparam int unsigned READY_CYCLES  = READY_TIME_MS * CYC_PER_MS;
  localparam int unsigned WAKE_TIME_MS  = 50;
  localparam int unsigned WAKE_CYCLES   = WAKE_TIME_MS * CYC_PER_MS;
  localparam int          TIMER_W       = 24;

  // two-wire slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR_RST = 7'h5a;

  // command codes, first byte of a write transfer
  localparam logic [7:0] CMD_DERIVE    = 8'h10;
  localparam logic [7:0] CMD_CHALLENGE = 8'h20;
  localparam logic [7:0] CMD_VERIFY    = 8'h30;

  // operand byte counts after the command byte
  localparam logic [4:0] DERIVE_BYTES = 5'h10;
  localparam logic [4:0] VERIFY_BYTES = 5'h08;

  // root secret kept scrambled; both values are arbitrary
  localparam logic [127:0] ROOT_OBSCURED =
    128'h3c1e_77a0_95d2_4b6f_08e1_c3a9_5f24_d71b;
  localparam logic [127:0] ROOT_MASK =
    128'ha5f0_0f5a_c33c_5aa5_9669_f00f_3cc3_6996;

  // single-block message padding
  localparam logic [7:0]  PAD_MARK   = 8'h80;
  localparam logic [63:0] LEN_DERIVE = 64'h0000_0000_0000_0100;
  localparam logic [63:0] LEN_VERIFY = 64'h0000_0000_0000_00e0;

  // hash constants
  localparam logic [159:0] SHA1_INIT =
    160'h67452301_efcdab89_98badcfe_10325476_c3d2e1f0;
  localparam logic [31:0] K_R0 = 32'h5a827999;
  localparam logic [31:0] K_R1 = 32'h6ed9eba1;
  localparam logic [31:0] K_R2 = 32'h8f1bbcdc;
  localparam logic [31:0] K_R3 = 32'hca62c1d6;
  localparam logic [6:0]  ROUND_LAST = 7'h4f;

  // random source, seed value is arbitrary
  localparam logic [63:0] RND_SEED = 64'h1f2e_3d4c_5b6a_7988;
  localparam logic [63:0] RND_TAPS = 64'hd800_0000_0000_0000;

endpackage : companion_pkg

// [design/companion_top.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - ready 60 ms after supply good or reset release; penalty extends
// - reset input low clears every internal state
// - reset acts even while sleep is requested
// - sleep request high: sleep and ignore all serial line transitions
// - after sleep request falls, no line transition accepted for 50 ms
// - operands concatenated in order, padded to one 64-byte block, hashed
// - hash handles a single block only, never chains blocks
// - tag secret is hash of root secret, tag id, host diversifier
// - challenge for mutual authentication comes from the random source
// - root secret stored obscured, tag secret held plain; used internally, never output
// - slave only on the two-wire bus, never stretches the clock
module companion_top #(
  parameter int unsigned READY_CYC = companion_pkg::READY_CYCLES,
  parameter int unsigned WAKE_CYC  = companion_pkg::WAKE_CYCLES,
  parameter logic [6:0]  DEV_ADDR  = companion_pkg::DEV_ADDR_RST
) (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic clk_en_i,
  input  wire logic supply_ok_i,
  input  wire logic penalty_active_i,
  input  wire logic sleep_request_pin_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n_o,
  output logic      ready_o,
  output logic      asleep_o,
  output logic      auth_ok_o
);
  localparam int TW = companion_pkg::TIMER_W;
  localparam logic [TW-1:0] READY_CNT = TW'(READY_CYC);
  localparam logic [TW-1:0] WAKE_CNT  = TW'(WAKE_CYC);

  typedef enum logic [2:0] {
    B_IDLE, B_ADDR, B_ACK_ADDR, B_RX, B_ACK_RX, B_TX, B_HACK
  } bus_e;
  typedef enum logic {OP_DERIVE, OP_VERIFY} op_e;

  // ---- input synchronisers: supply, penalty, sleep, scl, sda
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic       scl_q_r;
  logic       sda_q_r;
  logic       supply_s, penalty_s, sleep_s, scl_s, sda_s;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // both lines idle high, so reset leaves no false edge behind
      meta_r  <= 5'h03;
      sync_r  <= 5'h03;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (clk_en_i) begin
      meta_r  <= {supply_ok_i, penalty_active_i, sleep_request_pin_i,
                  scl_i, sda_i};
      sync_r  <= meta_r;
      scl_q_r <= sync_r[1];
      sda_q_r <= sync_r[0];
    end
  end

  assign {supply_s, penalty_s, sleep_s, scl_s, sda_s} = sync_r;

  // ---- ready and wake guard timers
  logic [TW-1:0] ready_cnt_r, ready_cnt_nxt;
  logic [TW-1:0] wake_cnt_r, wake_cnt_nxt;
  logic          ready;
  logic          bus_en;

  always_comb begin
    ready_cnt_nxt = ready_cnt_r;
    if (!supply_s) begin
      ready_cnt_nxt = READY_CNT;
    end else if (ready_cnt_r != '0 && !penalty_s) begin
      ready_cnt_nxt = ready_cnt_r - 1'b1;
    end
    wake_cnt_nxt = wake_cnt_r;
    if (sleep_s) begin
      wake_cnt_nxt = WAKE_CNT;
    end else if (wake_cnt_r != '0) begin
      wake_cnt_nxt = wake_cnt_r - 1'b1;
    end
  end

  // reset restarts the ready interval, independent of sleep
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ready_cnt_r <= READY_CNT;
      wake_cnt_r  <= '0;
    end else if (clk_en_i) begin
      ready_cnt_r <= ready_cnt_nxt;
      wake_cnt_r  <= wake_cnt_nxt;
    end
  end

  assign ready  = (ready_cnt_r == '0);
  assign bus_en = ready && !sleep_s && (wake_cnt_r == '0);

  // ---- crypto engine and random source
  hash_if hash ();
  logic [63:0] rnd;

  sha1_block u_hash (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .hash     (hash)
  );

  random_source #(.W(64)) u_rnd (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .value_o  (rnd)
  );

  // ---- two-wire slave
  bus_e        bus_r, bus_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic        full_r, full_nxt;
  logic        rw_r, rw_nxt;
  logic        oe_n_r, oe_n_nxt;
  logic        more_r, more_nxt;
  logic        first_r, first_nxt;
  logic [71:0] rd_buf_r, rd_buf_nxt;
  logic        rx_stb;
  logic        rx_first;
  logic        scl_rise, scl_fall, start_ev, stop_ev;
  logic [7:0]  status;

  logic [7:0]   cmd_r, cmd_nxt;
  logic [127:0] data_r, data_nxt;
  logic [4:0]   cnt_r, cnt_nxt;
  logic [159:0] g_r, g_nxt;
  logic         g_valid_r, g_valid_nxt;
  logic [63:0]  chal_r, chal_nxt;
  logic [63:0]  resp_r, resp_nxt;
  logic         auth_ok_r, auth_ok_nxt;
  op_e          mode_r, mode_nxt;
  logic         start_r, start_nxt;

  assign scl_rise = scl_s && !scl_q_r;
  assign scl_fall = !scl_s && scl_q_r;
  assign start_ev = scl_s && scl_q_r && sda_q_r && !sda_s;
  assign stop_ev  = scl_s && scl_q_r && !sda_q_r && sda_s;
  assign status   = {5'h00, g_valid_r, hash.busy, auth_ok_r};

  // scl is input only, so the slave can never hold it low
  always_comb begin
    bus_nxt    = bus_r;
    bit_nxt    = bit_r;
    sh_nxt     = sh_r;
    full_nxt   = full_r;
    rw_nxt     = rw_r;
    oe_n_nxt   = oe_n_r;
    more_nxt   = more_r;
    first_nxt  = first_r;
    rd_buf_nxt = rd_buf_r;
    rx_stb     = 1'b0;
    rx_first   = first_r;
    if (!bus_en) begin
      bus_nxt  = B_IDLE;
      oe_n_nxt = 1'b1;
      full_nxt = 1'b0;
    end else if (start_ev) begin
      bus_nxt  = B_ADDR;
      bit_nxt  = 3'h0;
      full_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end else if (stop_ev) begin
      bus_nxt  = B_IDLE;
      oe_n_nxt = 1'b1;
    end else begin
      case (bus_r)
        B_ADDR, B_RX: begin
          if (scl_rise && !full_r) begin
            sh_nxt   = {sh_r[6:0], sda_s};
            bit_nxt  = bit_r + 3'h1;
            full_nxt = (bit_r == 3'h7);
          end else if (scl_fall && full_r) begin
            full_nxt = 1'b0;
            bit_nxt  = 3'h0;
            if (bus_r == B_RX) begin
              rx_stb    = 1'b1;
              first_nxt = 1'b0;
              oe_n_nxt  = 1'b0;
              bus_nxt   = B_ACK_RX;
            end else if (sh_r[7:1] == DEV_ADDR) begin
              oe_n_nxt   = 1'b0;
              rw_nxt     = sh_r[0];
              first_nxt  = 1'b1;
              rd_buf_nxt = {status, chal_r};
              bus_nxt    = B_ACK_ADDR;
            end else begin
              bus_nxt = B_IDLE;
            end
          end
        end
        B_ACK_ADDR: begin
          if (scl_fall) begin
            bit_nxt = 3'h0;
            if (rw_r) begin
              oe_n_nxt = rd_buf_r[71];
              bus_nxt  = B_TX;
            end else begin
              oe_n_nxt = 1'b1;
              bus_nxt  = B_RX;
            end
          end
        end
        B_ACK_RX: begin
          if (scl_fall) begin
            oe_n_nxt = 1'b1;
            bus_nxt  = B_RX;
          end
        end
        B_TX: begin
          if (scl_fall) begin
            rd_buf_nxt = {rd_buf_r[70:0], 1'b0};
            if (bit_r == 3'h7) begin
              oe_n_nxt = 1'b1;
              bus_nxt  = B_HACK;
            end else begin
              oe_n_nxt = rd_buf_r[70];
              bit_nxt  = bit_r + 3'h1;
            end
          end
        end
        B_HACK: begin
          if (scl_rise) begin
            more_nxt = !sda_s;
          end else if (scl_fall) begin
            bit_nxt = 3'h0;
            if (more_r) begin
              oe_n_nxt = rd_buf_r[71];
              bus_nxt  = B_TX;
            end else begin
              bus_nxt = B_IDLE;
            end
          end
        end
        default: begin
          bus_nxt  = B_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_r    <= B_IDLE;
      bit_r    <= 3'h0;
      sh_r     <= 8'h00;
      full_r   <= 1'b0;
      rw_r     <= 1'b0;
      oe_n_r   <= 1'b1;
      more_r   <= 1'b0;
      first_r  <= 1'b0;
      rd_buf_r <= 72'h0;
    end else if (clk_en_i) begin
      bus_r    <= bus_nxt;
      bit_r    <= bit_nxt;
      sh_r     <= sh_nxt;
      full_r   <= full_nxt;
      rw_r     <= rw_nxt;
      oe_n_r   <= oe_n_nxt;
      more_r   <= more_nxt;
      first_r  <= first_nxt;
      rd_buf_r <= rd_buf_nxt;
    end
  end

  // ---- command execution
  // derive and verify commands arriving while the engine runs are dropped, not queued; challenge still runs
  always_comb begin
    cmd_nxt     = cmd_r;
    data_nxt    = data_r;
    cnt_nxt     = cnt_r;
    g_nxt       = g_r;
    g_valid_nxt = g_valid_r;
    chal_nxt    = chal_r;
    resp_nxt    = resp_r;
    auth_ok_nxt = auth_ok_r;
    mode_nxt    = mode_r;
    start_nxt   = 1'b0;
    if (rx_stb && rx_first) begin
      cmd_nxt = sh_r;
      cnt_nxt = 5'h00;
      if (sh_r == companion_pkg::CMD_CHALLENGE) begin
        chal_nxt    = rnd;
        auth_ok_nxt = 1'b0;
      end
    end else if (rx_stb) begin
      data_nxt = {data_r[119:0], sh_r};
      cnt_nxt  = cnt_r + 5'h01;
      if (!hash.busy && cmd_r == companion_pkg::CMD_DERIVE &&
          cnt_nxt == companion_pkg::DERIVE_BYTES) begin
        mode_nxt  = OP_DERIVE;
        start_nxt = 1'b1;
      end
      if (!hash.busy && g_valid_r &&
          cmd_r == companion_pkg::CMD_VERIFY &&
          cnt_nxt == companion_pkg::VERIFY_BYTES) begin
        mode_nxt    = OP_VERIFY;
        resp_nxt    = data_nxt[63:0];
        auth_ok_nxt = 1'b0;
        start_nxt   = 1'b1;
      end
    end
    if (hash.done) begin
      if (mode_r == OP_DERIVE) begin
        g_nxt       = hash.digest;
        g_valid_nxt = 1'b1;
      end else begin
        auth_ok_nxt = (hash.digest[159:96] == resp_r);
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_r     <= 8'h00;
      data_r    <= 128'h0;
      cnt_r     <= 5'h00;
      g_r       <= 160'h0;
      g_valid_r <= 1'b0;
      chal_r    <= 64'h0;
      resp_r    <= 64'h0;
      auth_ok_r <= 1'b0;
      mode_r    <= OP_DERIVE;
      start_r   <= 1'b0;
    end else if (clk_en_i) begin
      cmd_r     <= cmd_nxt;
      data_r    <= data_nxt;
      cnt_r     <= cnt_nxt;
      g_r       <= g_nxt;
      g_valid_r <= g_valid_nxt;
      chal_r    <= chal_nxt;
      resp_r    <= resp_nxt;
      auth_ok_r <= auth_ok_nxt;
      mode_r    <= mode_nxt;
      start_r   <= start_nxt;
    end
  end

  // operands in order, then marker, zeros and bit length in one block
  always_comb begin
    hash.start = start_r;
    if (mode_r == OP_DERIVE) begin
      hash.block = {companion_pkg::ROOT_OBSCURED ^ companion_pkg::ROOT_MASK,
                    data_r, companion_pkg::PAD_MARK, 184'h0,
                    companion_pkg::LEN_DERIVE};
    end else begin
      hash.block = {g_r, chal_r, companion_pkg::PAD_MARK, 216'h0,
                    companion_pkg::LEN_VERIFY};
    end
  end

  // open-drain data: only ever pulls low, secrets never reach the pins
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = oe_n_r;
  assign ready_o    = ready;
  assign asleep_o   = sleep_s;
  assign auth_ok_o  = auth_ok_r;

endmodule : companion_top

// [design/hash_if.sv]
`timescale 1ns/100ps
interface hash_if;
  logic         start;
  logic [511:0] block;
  logic         busy;
  logic         done;
  logic [159:0] digest;

  modport requester (output start, output block,
                     input busy, input done, input digest);
  modport engine    (input start, input block,
                     output busy, output done, output digest);
endinterface : hash_if

// [design/random_source.sv]
`timescale 1ns/100ps
module random_source #(
  parameter int W = 64
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic         clk_en_i,
  output logic      [W-1:0] value_o
);
  // free-running lfsr; a true entropy source would replace this core
  logic [W-1:0] lfsr_r;
  logic [W-1:0] lfsr_nxt;

  always_comb begin
    lfsr_nxt = {1'b0, lfsr_r[W-1:1]};
    if (lfsr_r[0]) begin
      lfsr_nxt = lfsr_nxt ^ companion_pkg::RND_TAPS[W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lfsr_r <= companion_pkg::RND_SEED[W-1:0];
    end else if (clk_en_i) begin
      lfsr_r <= lfsr_nxt;
    end
  end

  assign value_o = lfsr_r;
endmodule : random_source

// [design/sha1_block.sv]
`timescale 1ns/100ps
module sha1_block (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  hash_if.engine   hash
);
  // one compression only: the state is never fed back as a new chain value
  logic [31:0]  w_r [16];
  logic [31:0]  w_nxt [16];
  logic [159:0] st_r, st_nxt;
  logic [159:0] dig_r, dig_nxt;
  logic [6:0]   round_r, round_nxt;
  logic         run_r, run_nxt;
  logic         done_r, done_nxt;
  logic [31:0]  a, b, c, d, e, f, k, t;

  always_comb begin
    w_nxt     = w_r;
    st_nxt    = st_r;
    dig_nxt   = dig_r;
    round_nxt = round_r;
    run_nxt   = run_r;
    done_nxt  = 1'b0;
    {a, b, c, d, e} = st_r;
    if (round_r < 7'd20) begin
      f = (b & c) | (~b & d);
      k = companion_pkg::K_R0;
    end else if (round_r < 7'd40) begin
      f = b ^ c ^ d;
      k = companion_pkg::K_R1;
    end else if (round_r < 7'd60) begin
      f = (b & c) | (b & d) | (c & d);
      k = companion_pkg::K_R2;
    end else begin
      f = b ^ c ^ d;
      k = companion_pkg::K_R3;
    end
    t = {a[26:0], a[31:27]} + f + e + k + w_r[0];
    if (!run_r && hash.start) begin
      for (int i = 0; i < 16; i++) begin
        w_nxt[i] = hash.block[511-32*i -: 32];
      end
      st_nxt    = companion_pkg::SHA1_INIT;
      round_nxt = 7'h00;
      run_nxt   = 1'b1;
    end else if (run_r) begin
      st_nxt = {t, a, {b[1:0], b[31:2]}, c, d};
      for (int i = 0; i < 15; i++) begin
        w_nxt[i] = w_r[i+1];
      end
      w_nxt[15] = w_r[13] ^ w_r[8] ^ w_r[2] ^ w_r[0];
      w_nxt[15] = {w_nxt[15][30:0], w_nxt[15][31]};
      round_nxt = round_r + 7'd1;
      if (round_r == companion_pkg::ROUND_LAST) begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
        for (int i = 0; i < 5; i++) begin
          dig_nxt[159-32*i -: 32] = st_nxt[159-32*i -: 32]
            + companion_pkg::SHA1_INIT[159-32*i -: 32];
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 16; i++) begin
        w_r[i] <= 32'h0;
      end
      st_r    <= 160'h0;
      dig_r   <= 160'h0;
      round_r <= 7'h00;
      run_r   <= 1'b0;
      done_r  <= 1'b0;
    end else if (clk_en_i) begin
      w_r     <= w_nxt;
      st_r    <= st_nxt;
      dig_r   <= dig_nxt;
      round_r <= round_nxt;
      run_r   <= run_nxt;
      done_r  <= done_nxt;
    end
  end

  assign hash.busy   = run_r;
  assign hash.done   = done_r;
  assign hash.digest = dig_r;
endmodule : sha1_block

// [dv/companion_checker.sv]
`timescale 1ns/100ps
module companion_checker #(
  parameter int unsigned READY_CYC = 1,
  parameter int unsigned WAKE_CYC  = 3
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic supply_ok_i,
  input wire logic sleep_request_pin_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic ready_o,
  input wire logic asleep_o,
  input wire logic auth_ok_o
);
  logic [23:0] up_r, up_nxt, wk_r, wk_nxt;

  // wake counter starts saturated so a plain reset arms no guard
  always_comb begin
    up_nxt = supply_ok_i ? up_r + 24'h1 : 24'h0;
    wk_nxt = asleep_o ? 24'h0 : wk_r + {23'h0, wk_r < WAKE_CYC};
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_r <= 24'h0;
      wk_r <= 24'hffffff;
    end else begin
      up_r <= up_nxt;
      wk_r <= wk_nxt;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  chk_open_drain: assert property (sda_o == 1'b0)
    else $error("sda output level not low");
  chk_reset_clean: assert property ($rose(resetn_i) |->
    !ready_o && sda_oe_n_o && !asleep_o && !auth_ok_o)
    else $error("state survived reset");
  chk_supply_drop: assert property (!supply_ok_i [*4] |-> !ready_o)
    else $error("ready without supply");
  chk_ready_early: assert property ($rose(ready_o) |->
    up_r >= READY_CYC)
    else $error("ready came too early");
  chk_sleep_follow: assert property (
    sleep_request_pin_i [*4] |-> asleep_o)
    else $error("sleep request not followed");
  chk_wake_follow: assert property (
    !sleep_request_pin_i [*4] |-> !asleep_o)
    else $error("still asleep after request fell");
  chk_quiet_asleep: assert property (
    asleep_o [*2] |-> sda_oe_n_o)
    else $error("sda driven while asleep");
  chk_quiet_unready: assert property (
    !ready_o [*2] |-> sda_oe_n_o)
    else $error("sda driven before ready");
  chk_wake_guard: assert property (
    !asleep_o && (wk_r < WAKE_CYC - 2) |-> sda_oe_n_o)
    else $error("sda driven inside wake guard");
  chk_drive_scl_low: assert property (
    $changed(sda_oe_n_o) |-> !scl_i)
    else $error("sda drive changed while scl high");
  chk_auth_awake: assert property ($rose(auth_ok_o) |->
    ready_o && !asleep_o)
    else $error("auth flag set while not serving");

  cov_ready: cover property ($rose(ready_o));
  cov_ack:   cover property ($fell(sda_oe_n_o));
  cov_auth:  cover property ($rose(auth_ok_o));
  cov_wake:  cover property ($fell(asleep_o));
endmodule : companion_checker

bind companion_top companion_checker #(
  .READY_CYC(READY_CYC),
  .WAKE_CYC (WAKE_CYC)
) u_chk (
  .clock_i            (clock_i),
  .resetn_i           (resetn_i),
  .supply_ok_i        (supply_ok_i),
  .sleep_request_pin_i(sleep_request_pin_i),
  .scl_i              (scl_i),
  .sda_o              (sda_o),
  .sda_oe_n_o         (sda_oe_n_o),
  .ready_o            (ready_o),
  .asleep_o           (asleep_o),
  .auth_ok_o          (auth_ok_o)
);

// [dv/test_companion_top.sv]
`timescale 1ns/100ps
module test_companion_top;
  localparam int unsigned RDY = 400;
  localparam int unsigned WAK = 300;
  localparam logic [6:0]  ADR = companion_pkg::DEV_ADDR_RST;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic supply_ok_i = 1'b0;
  logic penalty_i = 1'b0;
  logic sleep_i = 1'b0;
  logic scl, pull, sda, sda_o, oe_n, ready, asleep, auth;
  logic [7:0] none [$];
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  // open-drain wire with board pull-up
  assign sda = ~(pull | ~oe_n);
  always #4 clock_i = ~clock_i;

  companion_top #(.READY_CYC(RDY), .WAKE_CYC(WAK)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
    .supply_ok_i(supply_ok_i), .penalty_active_i(penalty_i),
    .sleep_request_pin_i(sleep_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n_o(oe_n), .ready_o(ready),
    .asleep_o(asleep), .auth_ok_o(auth));
  twi_host host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
                 .sda_pull_o(pull));

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic check(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : check

  task automatic xfer(input logic [7:0] a, input logic [7:0] b[$],
                      input int n, output logic ack,
                      output logic [7:0] q[$]);
    logic k;
    logic [7:0] d;
    q = {};
    host.start_cond();
    host.send_byte(a, ack);
    if (!a[0]) foreach (b[i]) host.send_byte(b[i], k);
    else for (int i = 0; i < n; i++) begin
      host.recv_byte(i < n - 1, d);
      q.push_back(d);
    end
    host.stop_cond();
  endtask : xfer

  task automatic put64(inout logic [7:0] m[$], input logic [63:0] v);
    for (int i = 7; i >= 0; i--) m.push_back(v[8*i +: 8]);
  endtask : put64

  function automatic logic [159:0] sha1(input logic [511:0] m);
    logic [31:0] w [80];
    logic [31:0] a, b, c, d, e, f, k, t;
    logic [159:0] h;
    h = companion_pkg::SHA1_INIT;
    for (int i = 0; i < 80; i++) begin
      t = w[(i+77)%80] ^ w[(i+72)%80] ^ w[(i+66)%80] ^ w[(i+64)%80];
      w[i] = i < 16 ? m[511-32*i -: 32] : {t[30:0], t[31]};
    end
    {a, b, c, d, e} = h;
    for (int i = 0; i < 80; i++) begin
      f = i < 20 ? (b & c) | (~b & d) : (i < 40 || i >= 60) ?
          b ^ c ^ d : (b & c) | (b & d) | (c & d);
      k = i < 20 ? companion_pkg::K_R0 : i < 40 ? companion_pkg::K_R1 :
          i < 60 ? companion_pkg::K_R2 : companion_pkg::K_R3;
      t = {a[26:0], a[31:27]} + f + e + k + w[i];
      {e, d, c, b, a} = {d, c, b[1:0], b[31:2], a, t};
    end
    return {h[159:128] + a, h[127:96] + b, h[95:64] + c,
            h[63:32] + d, h[31:0] + e};
  endfunction : sha1

  // penalty held for pen cycles stretches the countdown by as much
  task automatic power_up(input int pen, output int n);
    @(posedge clock_i);
    supply_ok_i <= 1'b1;
    penalty_i <= pen > 0;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(posedge clock_i);
      n++;
      if (n == pen) penalty_i <= 1'b0;
    end
  endtask : power_up

  task automatic t_ready();
    logic ack;
    logic [7:0] q[$];
    int n;
    xfer({ADR, 1'b0}, none, 0, ack, q);
    check(ack === 1'b0, "address taken before ready");
    power_up(0, n);
    check(n >= RDY && n <= RDY + 5, "ready delay");
    xfer({ADR, 1'b0}, none, 0, ack, q);
    check(ack === 1'b1, "own address refused");
    xfer({ADR ^ 7'h01, 1'b0}, none, 0, ack, q);
    check(ack === 1'b0, "foreign address taken");
    supply_ok_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    check(ready === 1'b0, "ready kept after supply loss");
    power_up(150, n);
    check(n >= RDY + 150 && n <= RDY + 155, "penalty delay");
  endtask : t_ready

  task automatic t_sleep();
    logic ack;
    logic [7:0] q[$];
    sleep_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    check(asleep === 1'b1, "sleep not entered");
    xfer({ADR, 1'b0}, none, 0, ack, q);
    check(ack === 1'b0, "address taken asleep");
    sleep_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    check(asleep === 1'b0, "sleep not left");
    xfer({ADR, 1'b0}, none, 0, ack, q);
    check(ack === 1'b0, "address taken in wake guard");
    repeat (WAK) @(posedge clock_i);
    xfer({ADR, 1'b0}, none, 0, ack, q);
    check(ack === 1'b1, "address refused after wake");
  endtask : t_sleep

  task automatic t_auth();
    logic ack;
    logic [7:0] q[$], r[$], m[$];
    logic [63:0] id, dv, ch, pv;
    logic [159:0] g, h;
    id = 64'h0123_4567_89ab_cdef;
    dv = ~{id[31:0], id[63:32]};
    m = {companion_pkg::CMD_DERIVE};
    put64(m, id);
    put64(m, dv);
    xfer({ADR, 1'b0}, m, 0, ack, q);
    repeat (100) @(posedge clock_i);
    m = {companion_pkg::CMD_CHALLENGE};
    xfer({ADR, 1'b0}, m, 0, ack, q);
    xfer({ADR, 1'b1}, none, 10, ack, q);
    xfer({ADR, 1'b0}, m, 0, ack, r);
    xfer({ADR, 1'b1}, none, 9, ack, r);
    for (int i = 1; i < 9; i++) begin
      pv = {pv[55:0], q[i]};
      ch = {ch[55:0], r[i]};
    end
    check(q[0] === 8'h04, "status after challenge");
    check(q[9] === 8'h00, "data past challenge");
    check(ch !== pv, "challenge repeated");
    g = sha1({companion_pkg::ROOT_OBSCURED ^ companion_pkg::ROOT_MASK,
              id, dv, 8'h80, 184'h0, companion_pkg::LEN_DERIVE});
    h = sha1({g, ch, 8'h80, 216'h0, companion_pkg::LEN_VERIFY});
    m = {companion_pkg::CMD_VERIFY};
    put64(m, h[159:96] ^ 64'h1);
    xfer({ADR, 1'b0}, m, 0, ack, q);
    repeat (100) @(posedge clock_i);
    check(auth === 1'b0, "wrong response accepted");
    m = {companion_pkg::CMD_VERIFY};
    put64(m, h[159:96]);
    xfer({ADR, 1'b0}, m, 0, ack, q);
    repeat (100) @(posedge clock_i);
    check(auth === 1'b1, "derived secret mismatch");
    xfer({ADR, 1'b1}, none, 1, ack, q);
    check(q[0] === 8'h05, "status after verify");
  endtask : t_auth

  task automatic t_reset_sleep();
    logic ack;
    logic [7:0] q[$];
    int n;
    sleep_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    check(ready === 1'b0 && auth === 1'b0 && asleep === 1'b0 &&
          oe_n === 1'b1, "state kept in reset");
    resetn_i <= 1'b1;
    sleep_i <= 1'b0;
    power_up(0, n);
    xfer({ADR, 1'b1}, none, 1, ack, q);
    check(q[0] === 8'h00, "secret kept over reset");
  endtask : t_reset_sleep

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    t_ready();
    t_sleep();
    t_auth();
    t_reset_sleep();
    conclude();
  end
endmodule : test_companion_top

// [dv/twi_host.sv]
`timescale 1ns/100ps
module twi_host (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // bus idles with scl high and sda released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic start_cond();
    @(posedge clock_i);
    sda_pull_o <= 1'b0;
    repeat (5) @(posedge clock_i);
    scl_o <= 1'b1;
    repeat (10) @(posedge clock_i);
    sda_pull_o <= 1'b1;
    repeat (10) @(posedge clock_i);
    scl_o <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : start_cond

  task automatic stop_cond();
    @(posedge clock_i);
    sda_pull_o <= 1'b1;
    repeat (5) @(posedge clock_i);
    scl_o <= 1'b1;
    repeat (10) @(posedge clock_i);
    sda_pull_o <= 1'b0;
    repeat (10) @(posedge clock_i);
  endtask : stop_cond

  // data moves only well inside scl low, never near an scl edge
  task automatic bit_io(input logic b, output logic r);
    @(posedge clock_i);
    sda_pull_o <= ~b;
    repeat (5) @(posedge clock_i);
    scl_o <= 1'b1;
    repeat (10) @(posedge clock_i);
    r = sda_i;
    scl_o <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : bit_io

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte

  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask : recv_byte
endmodule : twi_host
